// >>> logic/ctmr_map.vh
/*
 Register offsets, field positions, reset values and codes of the
 counter/timer with capture and match.
 Assumes a 32-bit APB slave port with byte addresses, each register
 one aligned word.
*/
//
// Contract
// - Each instance has a 32-bit count stepped through a 32-bit prescaler.
// - The count source is the prescaled clock or edges of an external input.
// - Two capture channels store the count when their input transitions.
// - A capture event raises an interrupt only when enabled for that channel.
// - A chosen capture edge can clear both the count and the prescaler.
// - Four match registers; in continuous mode a match keeps counting.
// - Each match can optionally stop the counter, with optional interrupt.
// - Each match can optionally reset the count to zero, optional interrupt.
// - Two match outputs go low, go high, toggle or hold on their match.
// - Matches 0 and 1 can each raise a DMA request on their match.
// - Two independent instances exist, each with its own pins.
// - The count clock is the bus clock or an externally supplied clock.
// - A capture event copies the running count into that capture register.
// - A capture input may be chosen as the counting clock source.
// - A match is declared on the prescaled step taken while a match register equals the running count.
`ifndef CTMR_MAP_VH
`define CTMR_MAP_VH

`define CTMR_OFF_CTRL 8'h00
`define CTMR_OFF_COUNT 8'h04
`define CTMR_OFF_PRESCALE 8'h08
`define CTMR_OFF_PRE_COUNT 8'h0C
`define CTMR_OFF_SOURCE 8'h10
`define CTMR_OFF_MATCH_CTRL 8'h14
`define CTMR_OFF_CAP_CTRL 8'h18
`define CTMR_OFF_EXT_MATCH 8'h1C
`define CTMR_MATCH_PAGE 4'h2
`define CTMR_CAP_PAGE 5'h06
`define CTMR_OFF_INT_STATUS 8'h38
`define CTMR_OFF_INT_MASK 8'h3C
`define CTMR_OFF_DMA_CTRL 8'h40
`define CTMR_INST_BIT 8

`define CTMR_CTRL_EN 0
`define CTMR_CTRL_RST 1
`define CTMR_SRC_PCLK 2'h0
`define CTMR_SRC_EXT 2'h1
`define CTMR_SRC_CAP0 2'h2
`define CTMR_SRC_CAP1 2'h3
`define CTMR_MC_IRQ 0
`define CTMR_MC_RST 1
`define CTMR_MC_STOP 2
`define CTMR_CC_RISE 0
`define CTMR_CC_FALL 1
`define CTMR_CC_IRQ 2
`define CTMR_CC_CLR_EN 8
`define CTMR_CC_CLR_CH 9
`define CTMR_CC_CLR_RISE 10
`define CTMR_CC_CLR_FALL 11
`define CTMR_EM_ACT_LSB 4
`define CTMR_ACT_NONE 2'h0
`define CTMR_ACT_LOW 2'h1
`define CTMR_ACT_HIGH 2'h2
`define CTMR_ACT_TOGGLE 2'h3
`define CTMR_ZERO32 32'h00000000
`define CTMR_ONE32 32'h00000001

`endif

// >>> logic/ctmr_timer.v
/*
 Two counter/timer instances behind one APB slave port, each with a
 prescaled 32-bit count, four match registers, two capture channels,
 two match outputs and two DMA requests.
 Assumes all pins are synchronous to pclk and the APB master keeps
 address and data stable through each transfer.
*/
`timescale 1ns/1ns
`include "ctmr_map.vh"

module ctmr_core (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output wire pslverr,
  input wire cnt_clk_in,
  input wire [1:0] cap_in,
  input wire [1:0] dma_ack,
  output reg [1:0] match_out,
  output reg [1:0] dma_req,
  output wire irq
);

  // ****************************************************************
  // Registers and decode
  // ****************************************************************
  reg ctrl_en;
  reg ctrl_rst;
  reg [31:0] running_count_value;
  wire [31:0] next_count = running_count_value + `CTMR_ONE32;
  reg [31:0] pc;
  reg [31:0] pr;
  reg [1:0] src;
  reg [11:0] mctl;
  reg [11:0] cctl;
  reg [3:0] emr_act;
  reg [31:0] mr [0:3];
  reg [31:0] cr [0:1];
  reg [5:0] stat;
  reg [5:0] mask;
  reg [1:0] dma_en;
  reg prev_ext;
  reg [1:0] prev_cap;
  reg [31:0] rd_data;
  reg rd_ok;
  integer k;

  wire wr = psel & penable & pwrite;
  wire setup = psel & ~penable;
  wire wr_match = wr & (paddr[7:4] == `CTMR_MATCH_PAGE) &
                  (paddr[1:0] == 2'h0);
  assign pslverr = psel & penable & ~rd_ok;

  // ****************************************************************
  // Edges and count ticks
  // ****************************************************************
  wire ext_rise = cnt_clk_in & ~prev_ext;
  wire [1:0] cap_rise = cap_in & ~prev_cap;
  wire [1:0] cap_fall = ~cap_in & prev_cap;
  reg tick;

  always @* begin
    case (src)
      `CTMR_SRC_PCLK: tick = 1'b1;
      `CTMR_SRC_EXT: tick = ext_rise;
      `CTMR_SRC_CAP0: tick = cap_rise[0];
      `CTMR_SRC_CAP1: tick = cap_rise[1];
      default: tick = 1'b0;
    endcase
  end

  wire run = ctrl_en & ~ctrl_rst;
  wire step = run & tick & (pc == pr);

  wire [3:0] hit;
  wire [3:0] m_irq;
  wire [3:0] m_rst;
  wire [3:0] m_stop;
  wire [1:0] cap_ev;
  wire [1:0] c_irq;

  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1) begin : gm
      // A match acts on the prescaled step taken while count equals it.
      assign hit[g] = step & (running_count_value == mr[g]);
      assign m_irq[g] = mctl[3 * g + `CTMR_MC_IRQ];
      assign m_rst[g] = mctl[3 * g + `CTMR_MC_RST];
      assign m_stop[g] = mctl[3 * g + `CTMR_MC_STOP];
    end
    for (g = 0; g < 2; g = g + 1) begin : gc
      assign cap_ev[g] = (cctl[3 * g + `CTMR_CC_RISE] & cap_rise[g]) |
                         (cctl[3 * g + `CTMR_CC_FALL] & cap_fall[g]);
      assign c_irq[g] = cctl[3 * g + `CTMR_CC_IRQ];
    end
  endgenerate

  wire any_stop = |(hit & m_stop);
  wire any_rst = |(hit & m_rst);
  wire clr_ch = cctl[`CTMR_CC_CLR_CH];
  wire clr = cctl[`CTMR_CC_CLR_EN] &
             ((cctl[`CTMR_CC_CLR_RISE] & cap_rise[clr_ch]) |
              (cctl[`CTMR_CC_CLR_FALL] & cap_fall[clr_ch]));

  // ****************************************************************
  // Count and prescaler
  // ****************************************************************
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      running_count_value <= `CTMR_ZERO32;
      pc <= `CTMR_ZERO32;
    end else if (wr && paddr == `CTMR_OFF_COUNT) begin
      running_count_value <= pwdata;
      pc <= `CTMR_ZERO32;
    end else if (ctrl_rst || clr) begin
      running_count_value <= `CTMR_ZERO32;
      pc <= `CTMR_ZERO32;
    end else if (run && tick) begin
      if (pc == pr) begin
        pc <= `CTMR_ZERO32;
        if (any_stop)
          running_count_value <= running_count_value;
        else if (any_rst)
          running_count_value <= `CTMR_ZERO32;
        else
          running_count_value <= next_count;
      end else begin
        pc <= pc + `CTMR_ONE32;
      end
    end
  end

  // ****************************************************************
  // Control registers
  // ****************************************************************
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_en <= 1'b0;
      ctrl_rst <= 1'b0;
      pr <= `CTMR_ZERO32;
      src <= `CTMR_SRC_PCLK;
      mctl <= 12'h000;
      cctl <= 12'h000;
      mask <= 6'h00;
      dma_en <= 2'h0;
      for (k = 0; k < 4; k = k + 1)
        mr[k] <= `CTMR_ZERO32;
    end else begin
      if (any_stop)
        ctrl_en <= 1'b0;
      else if (wr && paddr == `CTMR_OFF_CTRL)
        ctrl_en <= pwdata[`CTMR_CTRL_EN];
      if (wr && paddr == `CTMR_OFF_CTRL)
        ctrl_rst <= pwdata[`CTMR_CTRL_RST];
      if (wr && paddr == `CTMR_OFF_PRESCALE)
        pr <= pwdata;
      if (wr && paddr == `CTMR_OFF_SOURCE)
        src <= pwdata[1:0];
      if (wr && paddr == `CTMR_OFF_MATCH_CTRL)
        mctl <= pwdata[11:0];
      if (wr && paddr == `CTMR_OFF_CAP_CTRL)
        cctl <= pwdata[11:0];
      if (wr && paddr == `CTMR_OFF_INT_MASK)
        mask <= pwdata[5:0];
      if (wr && paddr == `CTMR_OFF_DMA_CTRL)
        dma_en <= pwdata[1:0];
      if (wr_match)
        mr[paddr[3:2]] <= pwdata;
    end
  end

  // ****************************************************************
  // Capture, flags, outputs and DMA
  // ****************************************************************
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prev_ext <= 1'b0;
      prev_cap <= 2'h0;
      cr[0] <= `CTMR_ZERO32;
      cr[1] <= `CTMR_ZERO32;
    end else begin
      prev_ext <= cnt_clk_in;
      prev_cap <= cap_in;
      for (k = 0; k < 2; k = k + 1)
        if (cap_ev[k])
          cr[k] <= running_count_value;
    end
  end

  // A new event wins over a write-one clear in the same cycle.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn)
      stat <= 6'h00;
    else if (wr && paddr == `CTMR_OFF_INT_STATUS)
      stat <= (stat & ~pwdata[5:0]) | {cap_ev, hit};
    else
      stat <= stat | {cap_ev, hit};
  end

  assign irq = |(stat & mask & {c_irq, m_irq});

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      match_out <= 2'h0;
      emr_act <= 4'h0;
      dma_req <= 2'h0;
    end else begin
      if (wr && paddr == `CTMR_OFF_EXT_MATCH)
        emr_act <= pwdata[`CTMR_EM_ACT_LSB + 3:`CTMR_EM_ACT_LSB];
      for (k = 0; k < 2; k = k + 1) begin
        if (hit[k]) begin
          case (emr_act[2 * k +: 2])
            `CTMR_ACT_LOW: match_out[k] <= 1'b0;
            `CTMR_ACT_HIGH: match_out[k] <= 1'b1;
            `CTMR_ACT_TOGGLE: match_out[k] <= ~match_out[k];
            default: match_out[k] <= match_out[k];
          endcase
        end else if (wr && paddr == `CTMR_OFF_EXT_MATCH) begin
          match_out[k] <= pwdata[k];
        end
        if (hit[k] && dma_en[k])
          dma_req[k] <= 1'b1;
        else if (dma_ack[k])
          dma_req[k] <= 1'b0;
      end
    end
  end

  // ****************************************************************
  // Read path
  // ****************************************************************
  always @* begin
    rd_data = `CTMR_ZERO32;
    rd_ok = 1'b1;
    if (paddr[7:4] == `CTMR_MATCH_PAGE)
      rd_data = mr[paddr[3:2]];
    else if (paddr[7:3] == `CTMR_CAP_PAGE && paddr[1:0] == 2'h0)
      rd_data = cr[paddr[2]];
    else begin
      case (paddr)
        `CTMR_OFF_CTRL: rd_data = {30'h00000000, ctrl_rst, ctrl_en};
        `CTMR_OFF_COUNT: rd_data = running_count_value;
        `CTMR_OFF_PRESCALE: rd_data = pr;
        `CTMR_OFF_PRE_COUNT: rd_data = pc;
        `CTMR_OFF_SOURCE: rd_data = {30'h00000000, src};
        `CTMR_OFF_MATCH_CTRL: rd_data = {20'h00000, mctl};
        `CTMR_OFF_CAP_CTRL: rd_data = {20'h00000, cctl};
        `CTMR_OFF_EXT_MATCH: rd_data = {24'h000000, emr_act, 2'h0, match_out};
        `CTMR_OFF_INT_STATUS: rd_data = {26'h0000000, stat};
        `CTMR_OFF_INT_MASK: rd_data = {26'h0000000, mask};
        `CTMR_OFF_DMA_CTRL: rd_data = {28'h0000000, dma_req, dma_en};
        default: begin
          rd_data = `CTMR_ZERO32;
          rd_ok = 1'b0;
        end
      endcase
    end
    if (paddr[1:0] != 2'h0)
      rd_ok = 1'b0;
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn)
      prdata <= `CTMR_ZERO32;
    else if (setup && !pwrite)
      prdata <= rd_data;
  end

endmodule

// ******************************************************************
// Top: two instances, selected by one address bit
// ******************************************************************
module ctmr_timer (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output wire [31:0] prdata,
  output wire pready,
  output wire pslverr,
  output wire irq,
  input wire cnt_clk_a,
  input wire [1:0] cap_a,
  input wire [1:0] dma_ack_a,
  output wire [1:0] match_out_a,
  output wire [1:0] dma_req_a,
  input wire cnt_clk_b,
  input wire [1:0] cap_b,
  input wire [1:0] dma_ack_b,
  output wire [1:0] match_out_b,
  output wire [1:0] dma_req_b
);

  wire sel_b = paddr[`CTMR_INST_BIT];
  wire hi_ok = (paddr[11:`CTMR_INST_BIT + 1] == 3'h0);
  wire [31:0] rd_a;
  wire [31:0] rd_b;
  wire err_a;
  wire err_b;
  wire irq_a;
  wire irq_b;
  reg rd_sel_b;

  assign pready = 1'b1;
  assign prdata = rd_sel_b ? rd_b : rd_a;

  // The instance select is kept with the read data so that prdata stands
  // between reads even while the address moves to the other instance.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn)
      rd_sel_b <= 1'b0;
    else if (psel && !penable && !pwrite)
      rd_sel_b <= sel_b;
  end
  assign pslverr = (psel & penable & ~hi_ok) | (sel_b ? err_b : err_a);
  assign irq = irq_a | irq_b;

  // Each instance keeps its own pins and registers.
  ctmr_core timer_instance_a (
    .pclk(pclk),
    .presetn(presetn),
    .psel(psel & hi_ok & ~sel_b),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr[7:0]),
    .pwdata(pwdata),
    .prdata(rd_a),
    .pslverr(err_a),
    .cnt_clk_in(cnt_clk_a),
    .cap_in(cap_a),
    .dma_ack(dma_ack_a),
    .match_out(match_out_a),
    .dma_req(dma_req_a),
    .irq(irq_a)
  );

  ctmr_core timer_instance_b (
    .pclk(pclk),
    .presetn(presetn),
    .psel(psel & hi_ok & sel_b),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr[7:0]),
    .pwdata(pwdata),
    .prdata(rd_b),
    .pslverr(err_b),
    .cnt_clk_in(cnt_clk_b),
    .cap_in(cap_b),
    .dma_ack(dma_ack_b),
    .match_out(match_out_b),
    .dma_req(dma_req_b),
    .irq(irq_b)
  );

endmodule

// >>> bench/ctmr_asserts.sv
/* Port checks for ctmr_timer: bus answers, DMA hold and reset state.
   Assumes one clock pclk and the active-low reset presetn. */
`timescale 1ns/1ns
module ctmr_asserts (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic irq,
  input wire logic [1:0] match_out_a,
  input wire logic [1:0] dma_req_a,
  input wire logic [1:0] dma_ack_a,
  input wire logic [1:0] dma_req_b,
  input wire logic [1:0] dma_ack_b
);
  logic rd_setup;
  logic [1:0] hold_a;
  logic [1:0] hold_b;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  always_ff @(posedge pclk) begin
    rd_setup <= psel && !penable && !pwrite;
    hold_a <= dma_req_a & ~dma_ack_a;
    hold_b <= dma_req_b & ~dma_ack_b;
  end
  a_ready_high: assert property (pready)
    else $error("pready low");
  a_err_access: assert property (pslverr |-> psel && penable)
    else $error("pslverr outside access phase");
  a_err_upper: assert property (
    psel && penable && paddr[11:9] != 3'h0 |-> pslverr)
    else $error("upper address bits not refused");
  a_err_unmapped: assert property (psel && penable &&
    (paddr[7:0] > 8'h40 || paddr[1:0] != 2'h0) |-> pslverr)
    else $error("unmapped address not refused");
  a_rdata_hold: assert property (!rd_setup |-> $stable(prdata))
    else $error("prdata changed without read setup");
  a_dma_hold_a: assert property ((hold_a & ~dma_req_a) == 2'h0)
    else $error("dma_req_a dropped without ack");
  a_dma_hold_b: assert property ((hold_b & ~dma_req_b) == 2'h0)
    else $error("dma_req_b dropped without ack");
  a_reset_quiet: assert property ($rose(presetn) |->
    irq == 1'b0 && match_out_a == 2'h0 && dma_req_a == 2'h0)
    else $error("outputs not idle after reset");
endmodule

// >>> bench/ctmr_pins.sv
/* Pin model for the count and capture inputs of one instance.
   Assumes pulse is called right after a rising edge of pclk. */
`timescale 1ns/1ns
module ctmr_pins (
  input wire logic pclk,
  output logic cnt_clk,
  output logic [1:0] cap
);
  logic [2:0] pins = 3'h0;
  assign cnt_clk = pins[2];
  assign cap = pins[1:0];
  // High for two cycles and low for one, so each rise is seen once.
  task pulse(input int ln, input int n);
    repeat (n) begin
      @(posedge pclk);
      pins[ln] <= 1'b1;
      repeat (2) @(posedge pclk);
      pins[ln] <= 1'b0;
    end
  endtask
endmodule

// >>> bench/tb_counter_timer_capture_match.sv
/* Self-checking bench for ctmr_timer over APB.
   Assumes ctmr_pins drives instance a pins; instance b pins idle. */
`timescale 1ns/1ns
module tb_counter_timer_capture_match;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [1:0] dma_ack_a = 2'h0;
  logic [31:0] prdata, q;
  logic pready, pslverr, irq, cnt_clk_a, err;
  logic [1:0] cap_a, match_out_a, dma_req_a;
  logic [1:0] match_out_b, dma_req_b;
  int bad_count = 0;
  int samples_checked = 0;
  int i, j;
  always #5 pclk = ~pclk;
  ctmr_timer uut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .irq, .cnt_clk_a, .cap_a,
    .dma_ack_a, .match_out_a, .dma_req_a, .cnt_clk_b(1'b0),
    .cap_b(2'h0), .dma_ack_b(2'h0), .match_out_b, .dma_req_b);
  ctmr_pins pins (.pclk, .cnt_clk(cnt_clk_a), .cap(cap_a));
  task chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    samples_checked++;
    if (s !== e) begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", nm, e, s);
    end
  endtask
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task rd(input logic [11:0] a);
    apb(1'b0, a, 32'h0);
  endtask
  task close_out;
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    #200000;
    bad_count++;
    close_out;
  end
  initial begin
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd(12'h004);
    chk("count_reset", q, 32'h0);
    wr(12'h008, 32'h2);
    wr(12'h020, 32'h3);
    wr(12'h014, 32'h5);
    wr(12'h03C, 32'h1);
    wr(12'h000, 32'h1);
    for (i = 0; i < 60 && irq !== 1'b1; i++) @(posedge pclk);
    chk("prescale_wait", i > 6, 1'b1);
    rd(12'h004);
    chk("stop_count", q, 32'h3);
    rd(12'h000);
    chk("stop_enable", q, 32'h0);
    chk("irq_match", irq, 1'b1);
    wr(12'h038, 32'h1);
    chk("irq_cleared", irq, 1'b0);
    $display("prescale and stop test done");
    wr(12'h008, 32'h0);
    wr(12'h020, 32'h2);
    wr(12'h024, 32'h4);
    wr(12'h014, 32'h10);
    wr(12'h040, 32'h3);
    wr(12'h038, 32'h3F);
    wr(12'h000, 32'h1);
    repeat (30) @(posedge pclk);
    wr(12'h000, 32'h0);
    rd(12'h004);
    chk("reset_wrap", q <= 32'h4, 1'b1);
    rd(12'h038);
    chk("match_flags", q & 32'h3, 32'h3);
    chk("dma_both", dma_req_a, 2'h3);
    dma_ack_a <= 2'h3;
    @(posedge pclk);
    dma_ack_a <= 2'h0;
    @(posedge pclk);
    chk("dma_acked", dma_req_a, 2'h0);
    $display("continuous and reset test done");
    wr(12'h014, 32'h4);
    for (i = 0; i < 4; i++) begin
      wr(12'h01C, i * 16 + (i < 2));
      wr(12'h004, 32'h0);
      wr(12'h000, 32'h1);
      for (j = 0; j < 40 && dma_req_a[0] !== 1'b1; j++) @(posedge pclk);
      chk("match_out", match_out_a[0], i != 1);
      dma_ack_a <= 2'h1;
      @(posedge pclk);
      dma_ack_a <= 2'h0;
      @(posedge pclk);
    end
    rd(12'h004);
    chk("stop_at_match", q, 32'h2);
    $display("match output test done");
    wr(12'h014, 32'h0);
    for (i = 1; i < 4; i++) begin
      wr(12'h010, i);
      wr(12'h004, 32'h0);
      wr(12'h000, 32'h1);
      pins.pulse((i + 1) % 3, i + 1);
      rd(12'h004);
      chk("edge_count", q, i + 1);
    end
    $display("count source test done");
    wr(12'h010, 32'h0);
    wr(12'h018, 32'h70D);
    wr(12'h03C, 32'h30);
    wr(12'h038, 32'h3F);
    wr(12'h000, 32'h1);
    pins.pulse(1, 1);
    repeat (4) @(posedge pclk);
    pins.pulse(0, 1);
    rd(12'h030);
    chk("capture0", q, 32'h6);
    chk("irq_capture", irq, 1'b1);
    rd(12'h038);
    chk("cap_flags", q & 32'h30, 32'h30);
    wr(12'h038, 32'h10);
    chk("irq_silent", irq, 1'b0);
    $display("capture test done");
    wr(12'h104, 32'h5);
    rd(12'h104);
    chk("b_count", q, 32'h5);
    rd(12'h130);
    chk("b_capture", q, 32'h0);
    wr(12'h120, 32'h6);
    wr(12'h11C, 32'h20);
    wr(12'h140, 32'h1);
    wr(12'h100, 32'h1);
    repeat (4) @(posedge pclk);
    chk("b_match_out", match_out_b, 2'h1);
    chk("b_dma", dma_req_b, 2'h1);
    wr(12'h100, 32'h3);
    rd(12'h104);
    chk("b_hold", q, 32'h0);
    rd(12'h200);
    chk("upper_err", err, 1'b1);
    rd(12'h044);
    chk("unmapped_err", err, 1'b1);
    chk("unmapped_data", q, 32'h0);
    $display("instance and map test done");
    close_out;
  end
endmodule
bind ctmr_timer ctmr_asserts asserts_i (.pclk, .presetn, .psel, .penable,
  .pwrite, .paddr, .prdata, .pready, .pslverr, .irq, .match_out_a,
  .dma_req_a, .dma_ack_a, .dma_req_b, .dma_ack_b);
